// file: core/wpd_defines.svh
// Constants for the wake pattern frame detector
`ifndef WPD_DEFINES_SVH
`define WPD_DEFINES_SVH
`define WPD_SYNC_BYTE      8'hff
`define WPD_SYNC_LEN       3'h6
`define WPD_ADDR_BYTES     3'h6
`define WPD_REPEATS        5'h10
`define WPD_ENABLE_BIT     7
`define WPD_ISR_WAKE_BIT   4
`define WPD_CTRL_RESET     8'h00
`endif

// file: core/wpd_pkg.sv
// Types for the wake pattern frame detector
package wpd_pkg;
    typedef enum logic [1:0] {
        WPD_HUNT,
        WPD_BODY,
        WPD_FOUND
    } wpd_state_type;

    typedef struct packed {
        wpd_state_type state;
        logic [2:0]    syncCount;
        logic [2:0]    bytePos;
        logic [4:0]    repCount;
        logic          inFrame;
        logic          addrOk;
        logic          powerEventOut;
        logic          wakeStatus;
    } wpd_regs_type;
endpackage

// file: core/wpd_rx_if.sv
// Received byte stream carrier between MAC side and the scanner
`timescale 1ns/1ps
interface wpd_rx_if;
    logic       byteValid;
    logic [7:0] byteData;
    logic       frameStart;
    logic       frameEnd;
    logic       crcOk;
    logic       addrHit;
    modport src (output byteValid, byteData, frameStart, frameEnd, crcOk, addrHit);
    modport dst (input  byteValid, byteData, frameStart, frameEnd, crcOk, addrHit);
endinterface

// file: core/wpd_addr_sel.sv
// Station address byte selector, first transmitted byte at position zero
`timescale 1ns/1ps
module wpd_addr_sel
(
    // Address and position
    input  wire logic [47:0] stationAddr,
    input  wire logic [2:0]  bytePos,
    // Selected byte
    output logic      [7:0]  addrByte
);
    // ------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------
    always_comb
    begin
        addrByte = stationAddr[47:40];
        unique case (bytePos)
            3'h0: addrByte = stationAddr[47:40];
            3'h1: addrByte = stationAddr[39:32];
            3'h2: addrByte = stationAddr[31:24];
            3'h3: addrByte = stationAddr[23:16];
            3'h4: addrByte = stationAddr[15:8];
            3'h5: addrByte = stationAddr[7:0];
            default: addrByte = 8'h00;
        endcase
    end
endmodule

// file: core/wpd_detector.sv
// Wake pattern frame detector top
`timescale 1ns/1ps
`include "wpd_defines.svh"
module wpd_detector
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    // Control
    input  wire logic [7:0]          wakeupFrameControl,
    input  wire logic [47:0]         stationAddr,
    input  wire logic                statusClear,
    // Receive byte stream
    input  wire logic                rxByteValid,
    input  wire logic [7:0]          rxByteData,
    input  wire logic                rxFrameStart,
    input  wire logic                rxFrameEnd,
    input  wire logic                rxCrcOk,
    input  wire logic                rxAddrHit,
    // Wake indication
    output logic                     powerEventOut,
    output logic                     interruptStatusWake
);
    import wpd_pkg::*;

    wpd_rx_if rx();
    wpd_pkg::wpd_regs_type r;
    wpd_pkg::wpd_regs_type next_r;
    logic [7:0] addrByte;
    logic       enable;
    logic       isSync;
    logic       isAddr;
    logic       frameQualified;

    assign rx.byteValid  = rxByteValid;
    assign rx.byteData   = rxByteData;
    assign rx.frameStart = rxFrameStart;
    assign rx.frameEnd   = rxFrameEnd;
    assign rx.crcOk      = rxCrcOk;
    assign rx.addrHit    = rxAddrHit;

    wpd_addr_sel u_sel
    (
        .stationAddr (stationAddr),
        .bytePos     (r.bytePos),
        .addrByte    (addrByte)
    );

    // ------------------------------------------------------------
    // Byte scanner
    // ------------------------------------------------------------
    assign enable = wakeupFrameControl[`WPD_ENABLE_BIT];
    assign isSync = rx.byteData == `WPD_SYNC_BYTE;
    assign isAddr = rx.byteData == addrByte;
    // Address filter upstream flags own, multicast or broadcast hits
    assign frameQualified = rx.crcOk && rx.addrHit;

    always_comb
    begin
        next_r = r;
        if (rx.frameStart)
        begin
            next_r.inFrame   = enable;
            next_r.state     = WPD_HUNT;
            next_r.syncCount = 3'h0;
            next_r.bytePos   = 3'h0;
            next_r.repCount  = 5'h00;
        end
        else if (rx.byteValid && r.inFrame && r.state != WPD_FOUND)
        begin
            unique case (r.state)
                WPD_HUNT:
                begin
                    // Saturating count keeps the last six of a long FF run
                    if (isSync)
                        next_r.syncCount = (r.syncCount == `WPD_SYNC_LEN) ?
                                           r.syncCount : r.syncCount + 3'h1;
                    else
                        next_r.syncCount = 3'h0;
                    if (!isSync && r.syncCount == `WPD_SYNC_LEN && isAddr)
                    begin
                        next_r.state   = WPD_BODY;
                        next_r.bytePos = 3'h1;
                    end
                end
                WPD_BODY:
                begin
                    if (isAddr)
                    begin
                        if (r.bytePos == `WPD_ADDR_BYTES - 3'h1)
                        begin
                            next_r.bytePos  = 3'h0;
                            next_r.repCount = r.repCount + 5'h01;
                            if (r.repCount == `WPD_REPEATS - 5'h01)
                                next_r.state = WPD_FOUND;
                        end
                        else
                            next_r.bytePos = r.bytePos + 3'h1;
                    end
                    else
                    begin
                        // Restart; a FF here may already open a new sync run
                        next_r.state     = WPD_HUNT;
                        next_r.bytePos   = 3'h0;
                        next_r.repCount  = 5'h00;
                        next_r.syncCount = isSync ? 3'h1 : 3'h0;
                    end
                end
                WPD_FOUND:
                begin
                    next_r.state = WPD_FOUND;
                end
            endcase
        end
        // Decision only at frame end, once the CRC verdict is known
        if (rx.frameEnd && r.inFrame)
        begin
            next_r.inFrame = 1'b0;
            if (r.state == WPD_FOUND && frameQualified)
            begin
                next_r.powerEventOut = 1'b1;
                next_r.wakeStatus    = 1'b1;
            end
            next_r.state = WPD_HUNT;
        end
        // Set wins over a simultaneous clear
        if (statusClear && !(rx.frameEnd && r.inFrame && r.state == WPD_FOUND
                             && frameQualified))
        begin
            next_r.powerEventOut = 1'b0;
            next_r.wakeStatus    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign powerEventOut       = r.powerEventOut;
    assign interruptStatusWake = r.wakeStatus;
endmodule

// file: verification/wpd_chk.sv
// Port checker for the wake pattern frame detector
`timescale 1ns/1ps
module wpd_chk
(
    // Watched ports
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic statusClear,
    input wire logic rxFrameStart,
    input wire logic rxFrameEnd,
    input wire logic rxCrcOk,
    input wire logic rxAddrHit,
    input wire logic powerEventOut,
    input wire logic interruptStatusWake
);
    logic goodEnd;
    assign goodEnd = rxFrameEnd && rxCrcOk && rxAddrHit;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // An empty frame can never hold the pattern
    sequence s_emptyFrame; rxFrameStart ##1 rxFrameEnd; endsequence
    property p_setCause; $rose(powerEventOut) |-> $past(goodEnd); endproperty
    a_setCause: assert property (p_setCause) else $error("event without good frame end");
    property p_pair; powerEventOut == interruptStatusWake; endproperty
    a_pair: assert property (p_pair) else $error("status bit differs from event");
    property p_sticky; powerEventOut && !statusClear |=> powerEventOut; endproperty
    a_sticky: assert property (p_sticky) else $error("event dropped without clear");
    property p_clear; statusClear && !goodEnd |=> !interruptStatusWake; endproperty
    a_clear: assert property (p_clear) else $error("status survived clear");
    property p_crcBad; !powerEventOut && rxFrameEnd && !rxCrcOk |=> !powerEventOut; endproperty
    a_crcBad: assert property (p_crcBad) else $error("event on bad checksum");
    property p_addrMiss; !powerEventOut && !rxAddrHit |=> !powerEventOut; endproperty
    a_addrMiss: assert property (p_addrMiss) else $error("event on foreign frame");
    property p_atEnd; !powerEventOut && !rxFrameEnd |=> !powerEventOut; endproperty
    a_atEnd: assert property (p_atEnd) else $error("event away from frame end");
    property p_empty; s_emptyFrame |=> !$rose(powerEventOut); endproperty
    a_empty: assert property (p_empty) else $error("event on empty frame");
endmodule

bind wpd_detector wpd_chk wpd_chk_i (.*);

// file: verification/wpd_mac_model.sv
// MAC receive path model streaming queued frame bytes
`timescale 1ns/1ps
module wpd_mac_model
(
    // Clock
    input  wire logic  clk_sys,
    // Receive byte stream
    output logic       rxByteValid,
    output logic [7:0] rxByteData,
    output logic       rxFrameStart,
    output logic       rxFrameEnd,
    output logic       rxCrcOk,
    output logic       rxAddrHit
);
    logic [7:0] q[$];
    initial {rxByteValid, rxByteData, rxFrameStart, rxFrameEnd, rxCrcOk, rxAddrHit} = 13'h0;
    // Idle data is the inverted last byte so a stale value never looks fresh
    task automatic send(input logic crc, input logic hit);
        @(posedge clk_sys) rxFrameStart <= 1'b1;
        while (q.size() > 0)
            @(posedge clk_sys) {rxFrameStart, rxByteValid, rxByteData} <= {2'b01, q.pop_front()};
        @(posedge clk_sys) {rxFrameStart, rxByteValid} <= 2'b00;
        {rxFrameEnd, rxCrcOk, rxAddrHit, rxByteData} <= {1'b1, crc, hit, ~rxByteData};
        @(posedge clk_sys) {rxFrameEnd, rxCrcOk, rxAddrHit} <= 3'h0;
    endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the wake pattern frame detector
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys = 1'b0;
    logic        arst_n  = 1'b0;
    logic [7:0]  ctrl    = 8'h80;
    logic [47:0] addr    = 48'h0a1b2c3d4e5f;
    logic        clr     = 1'b0;
    logic        pwr, irq, vld, sof, eof, crc, hit;
    logic [7:0]  dat;
    int          fails, total_checks, cycles;
    wpd_mac_model wpd_mac_model_i (.clk_sys(clk_sys), .rxByteValid(vld), .rxByteData(dat),
        .rxFrameStart(sof), .rxFrameEnd(eof), .rxCrcOk(crc), .rxAddrHit(hit));
    wpd_detector wpd_detector_i (.clk_sys(clk_sys), .arst_n(arst_n), .wakeupFrameControl(ctrl),
        .stationAddr(addr), .statusClear(clr), .rxByteValid(vld), .rxByteData(dat),
        .rxFrameStart(sof), .rxFrameEnd(eof), .rxCrcOk(crc), .rxAddrHit(hit),
        .powerEventOut(pwr), .interruptStatusWake(irq));
    always #5 clk_sys = ~clk_sys;
    // A whole run needs under two thousand cycles
    always @(posedge clk_sys)
        if (++cycles >= 6000)
        begin
            fails++;
            wrap_up();
        end
    task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t outputs %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic run(int ff, int reps, bit rev, logic c, logic h, logic [1:0] exp);
        repeat (ff) wpd_mac_model_i.q.push_back(8'hff);
        repeat (reps)
            for (int i = 0; i < 6; i++)
                wpd_mac_model_i.q.push_back(rev ? addr[8*i+:8] : addr[47-8*i-:8]);
        wpd_mac_model_i.send(c, h);
        #1 chk({pwr, irq}, exp);
        @(posedge clk_sys) clr <= 1'b1;
        #1 chk({pwr, irq}, exp);
        @(posedge clk_sys) clr <= 1'b0;
        #1 chk({pwr, irq}, 2'b00);
    endtask
    task automatic s_match;
        wpd_mac_model_i.q = {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, addr[47:40], addr[39:32]};
        run(8, 16, 0, 1, 1, 2'b11);
    endtask
    task automatic s_partial;
        run(6, 15, 0, 1, 1, 2'b00);
        run(5, 16, 0, 1, 1, 2'b00);
        run(6, 16, 1, 1, 1, 2'b00);
        run(0, 0, 0, 1, 1, 2'b00);
    endtask
    task automatic s_refused;
        run(6, 16, 0, 0, 1, 2'b00);
        run(6, 16, 0, 1, 0, 2'b00);
        @(posedge clk_sys) ctrl <= 8'h7f;
        run(6, 16, 0, 1, 1, 2'b00);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        s_match();
        s_partial();
        s_refused();
        wrap_up();
    end
endmodule
